/* hdl/two_wire_irq_mask_and_holding.sv */
// Interrupt mask, status flags and holding bytes of the two-wire master controller.
//
// How it works
// R01: Writing the enable register sets mask bits where written bits are one.
// R02: Writing the disable register clears mask bits where written bits are one.
// R03: The mask view reads current enables; writes to it do nothing.
// R04: Sources sit at bits 0,1,2,6,7,8; all other bits reserved, read zero, except status bit 3, which resets to one and reads one.
// R05: Receive holding is read-only and shows the last received byte.
// R06: Transmit holding keeps the next byte in bits 7..0, readable and writable.
// R07: Transmit-free clears on holding write, sets on shifter load, nack or enable.
// R08: Receive-waiting sets when a byte lands, clears when holding is read.
// R09: Overrun/underrun clear on status read only with done; nack clears on read.
// R10: The interrupt output is high one cycle after any unmasked status flag is set, low one cycle after none is.
`timescale 1ns/1ps
`include "two_wire_irq_regs.svh"

module two_wire_irq_mask_and_holding
    import two_wire_irq_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [`ADDR_W-1:0]  addr,
    input  wire word_t               wrData,
    input  wire logic                wrStb,
    input  wire logic                rdStb,
    output word_t                    rdData,
    output logic                     irq,
    input  wire logic                rxLoad,
    input  wire byte_t               rxByteIn,
    input  wire logic                txTake,
    input  wire logic                nackSeen,
    input  wire logic                frameDone,
    input  wire logic                frameStart,
    input  wire logic                underrunSeen,
    output byte_t                    txByteOut,
    output logic                     txPending,
    output logic                     masterOn
);

    srcVec_t mask_q;
    srcVec_t status_q;
    byte_t   rxByte_q;
    byte_t   txByte_q;
    logic    txPend_q;
    logic    masterOn_q;
    word_t   rdData_q;
    logic    irq_q;

    // Decodes a strobed access to one register offset.
    function automatic logic hit(input logic stb, input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] ofs);
        hit = stb && (a == ofs);
    endfunction

    logic wrSet, wrClr, wrTx, wrCtrl, rdStat, rdRx, msenWr;
    assign wrSet  = hit(wrStb, addr, `IRQ_SET_OFS);
    assign wrClr  = hit(wrStb, addr, `IRQ_CLR_OFS);
    assign wrTx   = hit(wrStb, addr, `TX_HOLD_OFS);
    assign wrCtrl = hit(wrStb, addr, `CTRL_OFS);
    assign rdStat = hit(rdStb, addr, `STATUS_OFS);
    assign rdRx   = hit(rdStb, addr, `RX_HOLD_OFS);
    assign msenWr = wrCtrl && wrData[`CTRL_BIT_MASTER_TRANSFER_ON] && !wrData[`CTRL_BIT_MSDIS];

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt mask.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 9'h000;
        end else begin
            mask_q <= (mask_q | (wrSet ? wrData[8:0] & `SRC_MASK : 9'h000)) // see R01
                      & ~(wrClr ? wrData[8:0] & `SRC_MASK : 9'h000);        // see R02
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Master enable state from the control register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            masterOn_q <= 1'b0;
        end else if (wrCtrl && wrData[`CTRL_BIT_MSDIS]) begin
            masterOn_q <= 1'b0;
        end else if (msenWr) begin
            masterOn_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags; a setting event wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= `STATUS_RESET;
        end else begin
            if (frameDone || nackSeen || msenWr) begin
                status_q[`BIT_DONE] <= 1'b1;
            end else if (frameStart) begin
                status_q[`BIT_DONE] <= 1'b0;
            end
            if (txTake || nackSeen || msenWr) begin
                status_q[`BIT_TXFREE] <= 1'b1;                  // see R07
            end else if (wrTx) begin
                status_q[`BIT_TXFREE] <= 1'b0;                  // see R07
            end
            if (rxLoad) begin
                status_q[`BIT_RXWAIT] <= 1'b1;                  // see R08
            end else if (rdRx) begin
                status_q[`BIT_RXWAIT] <= 1'b0;                  // see R08
            end
            if (rxLoad && status_q[`BIT_RXWAIT] && !rdRx) begin
                status_q[`BIT_OVERRUN] <= 1'b1;
            end else if (rdStat && status_q[`BIT_DONE]) begin
                status_q[`BIT_OVERRUN] <= 1'b0;                 // see R09
            end
            if (underrunSeen) begin
                status_q[`BIT_UNDERRUN] <= 1'b1;
            end else if (rdStat && status_q[`BIT_DONE]) begin
                status_q[`BIT_UNDERRUN] <= 1'b0;                // see R09
            end
            if (nackSeen) begin
                status_q[`BIT_NACK] <= 1'b1;
            end else if (rdStat) begin
                status_q[`BIT_NACK] <= 1'b0;                    // see R09
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Holding bytes and shifter hand-off.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxByte_q <= 8'h00;
        end else if (rxLoad) begin
            rxByte_q <= rxByteIn;                               // see R05
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txByte_q <= 8'h00;
        end else if (wrTx) begin
            txByte_q <= wrData[7:0];                            // see R06
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txPend_q <= 1'b0;
        end else if (wrTx) begin
            txPend_q <= 1'b1;
        end else if (txTake || nackSeen) begin
            txPend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= 32'h0000_0000;
        end else if (rdStb) begin
            unique case (addr)
                `STATUS_OFS:   rdData_q <= {23'h000000, status_q};
                `IRQ_VIEW_OFS: rdData_q <= {23'h000000, mask_q};    // see R03 R04
                `RX_HOLD_OFS:  rdData_q <= {24'h000000, rxByte_q};  // see R05
                `TX_HOLD_OFS:  rdData_q <= {24'h000000, txByte_q};  // see R06
                default:       rdData_q <= 32'h0000_0000;
            endcase
        end else begin
            rdData_q <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);                      // see R10
        end
    end

    assign rdData    = rdData_q;
    assign irq       = irq_q;
    assign txByteOut = txByte_q;
    assign txPending = txPend_q;
    assign masterOn  = masterOn_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_enable_sets: assert property (@(posedge clk) disable iff (!rst_n) // see R01
        wrSet && !wrClr |=> ((mask_q & ($past(wrData[8:0]) & `SRC_MASK))
                             == ($past(wrData[8:0]) & `SRC_MASK)))
        else $error("Enable write did not set mask bits.");

    a_disable_clears: assert property (@(posedge clk) disable iff (!rst_n) // see R02
        wrClr |=> ((mask_q & $past(wrData[8:0])) == 9'h000))
        else $error("Disable write did not clear mask bits.");

    a_mask_view: assert property (@(posedge clk) disable iff (!rst_n) // see R03
        rdStb && addr == `IRQ_VIEW_OFS && !wrStb |=> rdData == {23'h000000, $past(mask_q)})
        else $error("Mask view differs from mask.");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // see R04
        (mask_q & ~`SRC_MASK) == 9'h000)
        else $error("Reserved mask bit set.");

    a_rx_capture: assert property (@(posedge clk) disable iff (!rst_n) // see R05
        rxLoad ##1 !rxLoad ##1 (rdStb && addr == `RX_HOLD_OFS && !rxLoad)
        |=> rdData[7:0] == $past(rxByteIn, 3))
        else $error("Receive holding lost the byte.");

    a_tx_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R06
        wrTx |=> txByteOut == $past(wrData[7:0]))
        else $error("Transmit holding not written.");

    a_txfree_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R07
        wrTx && !txTake && !nackSeen && !msenWr |=> !status_q[`BIT_TXFREE])
        else $error("Transmit-free not cleared by write.");

    a_rxwait_flag: assert property (@(posedge clk) disable iff (!rst_n) // see R08
        rxLoad |=> status_q[`BIT_RXWAIT])
        else $error("Receive-waiting not set.");

    a_err_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        rdStat && !status_q[`BIT_DONE] && !underrunSeen && status_q[`BIT_UNDERRUN]
        |=> status_q[`BIT_UNDERRUN])
        else $error("Underrun cleared without transfer done.");

    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        ##1 irq == |($past(status_q) & $past(mask_q)))
        else $error("Interrupt level wrong.");

    a_done_set: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        frameDone || nackSeen || msenWr |=> status_q[`BIT_DONE])
        else $error("Transfer done not set.");

    a_done_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        frameStart && !frameDone && !nackSeen && !msenWr |=> !status_q[`BIT_DONE])
        else $error("Transfer done not cleared by frame start.");

    a_txfree_set: assert property (@(posedge clk) disable iff (!rst_n) // see R07
        txTake || nackSeen || msenWr |=> status_q[`BIT_TXFREE])
        else $error("Transmit-free not set.");

    a_txfree_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R07
        !txTake && !nackSeen && !msenWr && !wrTx |=> $stable(status_q[`BIT_TXFREE]))
        else $error("Transmit-free changed without cause.");

    a_rxwait_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R08
        rdRx && !rxLoad |=> !status_q[`BIT_RXWAIT])
        else $error("Receive-waiting not cleared by read.");

    a_rxwait_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R08
        !rxLoad && !rdRx |=> $stable(status_q[`BIT_RXWAIT]))
        else $error("Receive-waiting changed without cause.");

    a_overrun_set: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        rxLoad && status_q[`BIT_RXWAIT] && !rdRx |=> status_q[`BIT_OVERRUN])
        else $error("Overrun not set.");

    a_overrun_keep: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        rdStat && !status_q[`BIT_DONE] && status_q[`BIT_OVERRUN] |=> status_q[`BIT_OVERRUN])
        else $error("Overrun cleared without transfer done.");

    a_overrun_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        rdStat && status_q[`BIT_DONE] && !rxLoad |=> !status_q[`BIT_OVERRUN])
        else $error("Overrun not cleared by status read.");

    a_underrun_set: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        underrunSeen |=> status_q[`BIT_UNDERRUN])
        else $error("Underrun not set.");

    a_underrun_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        rdStat && status_q[`BIT_DONE] && !underrunSeen |=> !status_q[`BIT_UNDERRUN])
        else $error("Underrun not cleared by status read.");

    a_nack_set: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        nackSeen |=> status_q[`BIT_NACK] && status_q[`BIT_DONE])
        else $error("Nack not set with transfer done.");

    a_nack_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        rdStat && !nackSeen |=> !status_q[`BIT_NACK])
        else $error("Nack not cleared by status read.");

    a_nack_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        !nackSeen && !rdStat |=> $stable(status_q[`BIT_NACK]))
        else $error("Nack changed without cause.");

    a_status_read: assert property (@(posedge clk) disable iff (!rst_n) // see R09
        rdStat |=> rdData == {23'h000000, $past(status_q)})
        else $error("Status read returned wrong value.");

    a_status_reserved: assert property (@(posedge clk) disable iff (!rst_n) // see R04
        (status_q & ~(`SRC_MASK | 9'h008)) == 9'h000)
        else $error("Reserved status bit set.");

    a_rx_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R05
        rxLoad |=> rxByte_q == $past(rxByteIn))
        else $error("Receive holding not loaded.");

    a_rx_readonly: assert property (@(posedge clk) disable iff (!rst_n) // see R05
        !rxLoad |=> $stable(rxByte_q))
        else $error("Receive holding changed without a load.");

    a_rx_read: assert property (@(posedge clk) disable iff (!rst_n) // see R05
        rdRx |=> rdData == {24'h000000, $past(rxByte_q)})
        else $error("Receive holding read returned wrong value.");

    a_tx_keep: assert property (@(posedge clk) disable iff (!rst_n) // see R06
        !wrTx |=> $stable(txByte_q))
        else $error("Transmit holding changed without a write.");

    a_tx_read: assert property (@(posedge clk) disable iff (!rst_n) // see R06
        rdStb && addr == `TX_HOLD_OFS |=> rdData == {24'h000000, $past(txByte_q)})
        else $error("Transmit holding read returned wrong value.");

    a_pend_set: assert property (@(posedge clk) disable iff (!rst_n) // see R07
        wrTx |=> txPending)
        else $error("Transmit pending not set by write.");

    a_pend_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R07
        !wrTx && (txTake || nackSeen) |=> !txPending)
        else $error("Transmit pending not cleared.");

    a_master_on: assert property (@(posedge clk) disable iff (!rst_n) // see R07
        msenWr |=> masterOn)
        else $error("Master enable not set.");

    a_master_off: assert property (@(posedge clk) disable iff (!rst_n) // see R07
        wrCtrl && wrData[`CTRL_BIT_MSDIS] |=> !masterOn)
        else $error("Master disable not honoured.");

    a_mask_keep: assert property (@(posedge clk) disable iff (!rst_n) // see R03
        !wrSet && !wrClr |=> $stable(mask_q))
        else $error("Mask changed without an enable or disable write.");

    a_read_idle: assert property (@(posedge clk) disable iff (!rst_n) // see R03
        !rdStb |=> rdData == 32'h0000_0000)
        else $error("Read data not zero outside a read.");

    a_irq_on: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        |(status_q & mask_q) |=> irq)
        else $error("Interrupt not raised.");

    a_irq_off: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        mask_q == 9'h000 |=> !irq)
        else $error("Interrupt raised with all sources masked.");

endmodule

/* inc/two_wire_irq_regs.svh */
// Register offsets, field positions and reset values of the interrupt and holding block.
`ifndef TWO_WIRE_IRQ_REGS_SVH
`define TWO_WIRE_IRQ_REGS_SVH

`define STATUS_OFS      8'h20
`define IRQ_SET_OFS     8'h24
`define IRQ_CLR_OFS     8'h28
`define IRQ_VIEW_OFS    8'h2c
`define RX_HOLD_OFS     8'h30
`define TX_HOLD_OFS     8'h34
`define CTRL_OFS        8'h00

`define BIT_DONE        0
`define BIT_RXWAIT      1
`define BIT_TXFREE      2
`define BIT_OVERRUN     6
`define BIT_UNDERRUN    7
`define BIT_NACK        8

`define CTRL_BIT_MASTER_TRANSFER_ON   2
`define CTRL_BIT_MSDIS  3

`define SRC_MASK        9'h1c7
`define STATUS_RESET    9'h008
`define ADDR_W          8

`endif

/* inc/two_wire_irq_pkg.sv */
// Types shared by the interrupt and holding block.
package two_wire_irq_pkg;
    typedef logic [31:0] word_t;
    typedef logic [8:0]  srcVec_t;
    typedef logic [7:0]  byte_t;
endpackage

/* dv/tb.sv */
// Self-checking bench of the interrupt mask and holding block.
`timescale 1ns/1ps
`include "two_wire_irq_regs.svh"

module tb import two_wire_irq_pkg::*; ();
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [`ADDR_W-1:0] addr = '0;
    word_t             wrData = '0;
    word_t             rdData;
    logic              wrStb = 1'b0;
    logic              rdStb = 1'b0;
    logic              irq;
    logic [5:0]        ev_q = '0;
    byte_t             rxByteIn = '0;
    byte_t             txByteOut;
    logic              txPending;
    logic              masterOn;
    int                nMismatch = 0;
    int                nChecks = 0;
    byte_t             rnd = 8'h5c;
    byte_t             b;
    word_t             got;
    word_t             w;
    srcVec_t           msk = '0;

    always #25 clk = ~clk;

    two_wire_irq_mask_and_holding dut_u (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .irq(irq), .rxLoad(ev_q[5]), .rxByteIn(rxByteIn),
        .txTake(ev_q[4]), .nackSeen(ev_q[3]), .frameDone(ev_q[2]), .frameStart(ev_q[1]),
        .underrunSeen(ev_q[0]), .txByteOut(txByteOut), .txPending(txPending),
        .masterOn(masterOn));

    ////////////////////////////////////////////////////////////////////////////////
    // Stimulus helpers.
    function automatic byte_t nxt(byte_t x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    task automatic chk(word_t g, word_t e);
        nChecks++;
        if (g !== e) begin
            nMismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(logic [7:0] a, word_t d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 got = rdData;
    endtask

    task automatic ev(logic [5:0] v, byte_t d);
        @(posedge clk);
        ev_q <= v;
        rxByteIn <= d;
        @(posedge clk);
        ev_q <= 6'h00;
    endtask

    task automatic st(word_t e);
        rd(`STATUS_OFS);
        chk(got & 32'h000001c7, e);
    endtask

    task automatic report_and_stop();
        if (nMismatch == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(`IRQ_VIEW_OFS); chk(got, 32'h0);
        rd(`STATUS_OFS); chk(got, 32'h8);
        rd(`TX_HOLD_OFS); chk(got, 32'h0);
        rd(8'h3c); chk(got, 32'h0);
        wr(`IRQ_SET_OFS, 32'hffffffff);
        msk = `SRC_MASK;
        rd(`IRQ_VIEW_OFS); chk(got, 32'h1c7);
        for (int i = 0; i < 24; i++) begin
            rnd = nxt(rnd);
            w = {nxt(rnd), rnd ^ 8'h3a, nxt(nxt(rnd)), rnd};
            if (i == 9) begin
                wr(`IRQ_VIEW_OFS, ~{23'h0, msk});
            end else if (rnd[3]) begin
                wr(`IRQ_SET_OFS, w);
                msk = msk | (w[8:0] & `SRC_MASK);
            end else begin
                wr(`IRQ_CLR_OFS, w);
                msk = msk & ~w[8:0];
            end
            rd(`IRQ_VIEW_OFS); chk(got, {23'h0, msk});
        end
        for (int i = 0; i < 4; i++) begin
            rnd = nxt(rnd);
            b = rnd;
            wr(`TX_HOLD_OFS, {nxt(b), 16'hbeef, b});
            rd(`TX_HOLD_OFS); chk(got, {24'h0, b});
            chk({23'h0, txPending, txByteOut}, {23'h1, b});
            st(32'h0);
            ev(6'h10, 8'h00);
            st(32'h4);
        end
        wr(`IRQ_CLR_OFS, 32'hffffffff);
        wr(`IRQ_SET_OFS, 32'h2);
        ev(6'h20, 8'h5a);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h1);
        st(32'h6);
        ev(6'h20, 8'ha7);
        rd(`RX_HOLD_OFS); chk(got, 32'ha7);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h0);
        st(32'h44);
        st(32'h44);
        ev(6'h04, 8'h00);
        st(32'h45);
        st(32'h05);
        wr(`IRQ_SET_OFS, 32'h100);
        ev(6'h08, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h1);
        wr(`IRQ_CLR_OFS, 32'h100);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h0);
        st(32'h105);
        st(32'h05);
        ev(6'h01, 8'h00);
        st(32'h85);
        st(32'h05);
        wr(`TX_HOLD_OFS, 32'h3c);
        ev(6'h02, 8'h00);
        st(32'h0);
        wr(`CTRL_OFS, 32'h4);
        st(32'h5);
        chk({31'h0, masterOn}, 32'h1);
        report_and_stop();
    end
endmodule
